// File: pch_header_bank.sv
// Configuration header bank: host config port, local header view, window decode
//
// What this block does
// R1 - Local reads of header at word-indexed addresses
// R2 - Claim host access only on base match
// R3 - Base registers support write-ones sizing readback
// R4 - Window zero: 256-byte memory register window
// R5 - Window one: 256-byte I/O register window
// R6 - Window two: 2 MB memory pass-through
// R7 - Pass-through mapping loaded from NVRAM
// R8 - Window three and ROM report nothing
// R9 - Class code reports no defined class
// R10 - Initial header values loaded from NVRAM
// R11 - Answer configuration only when slot selected
// R12 - Host places memory windows above 1 MB
// R13 - Read-only fields ignore writes, reserved zero
`timescale 1ns/100ps
module pch_header_bank
  import pch_pkg::*;
#(
  parameter int NV_HALF_CYC = NV_SCK_HALF_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic cfg_sel,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [5:0] cfg_ofs,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_ack,
  input wire logic dsp_rd,
  input wire logic [23:0] dsp_addr,
  output logic [31:0] dsp_rdata,
  output logic dsp_ack,
  input wire logic acc_valid,
  input wire logic acc_io,
  input wire logic [31:0] acc_addr,
  output logic acc_claim,
  output logic [1:0] acc_window,
  output logic [7:0] acc_opreg_ofs,
  output logic [23:0] acc_local_addr,
  input wire logic nv_miso,
  output logic nv_cs_n,
  output logic nv_sck,
  output logic nv_mosi,
  output logic header_ready
);

  // ----------------
  // Helpers
  // ----------------
  function automatic logic [31:0] be_merge(
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] hdr_view(
    input logic [5:0] ofs,
    input logic [31:0] img,
    input logic [15:0] cmd,
    input logic [15:0] lat_cls,
    input logic [31:WIN0_LSB] b0,
    input logic [31:WIN1_LSB] b1,
    input logic [31:WIN2_LSB] b2,
    input logic [7:0] irq_line
  );
    logic [31:0] res;
    res = 32'h00000000;
    case ({ofs[5:2], 2'b00})
      OFS_IDENTITY_WORD: res = img;
      OFS_STATUS_COMMAND_WORD: res = {img[31:16], cmd};
      OFS_CLASS_REVISION_WORD: res = {CLASS_NONE, img[7:0]}; // R9
      OFS_SELFTEST_HEADER_LATENCY_LINE: res = {img[31:16], lat_cls};
      OFS_WINDOW0_BASE: res = {b0, WIN0_LOW}; // R3
      OFS_WINDOW1_BASE: res = {b1, WIN1_LOW}; // R3
      OFS_WINDOW2_BASE: res = {b2, WIN2_LOW}; // R3
      OFS_CARD_INFO_POINTER: res = img;
      OFS_SUBSYSTEM_IDENTITY_WORD: res = img;
      OFS_GRANT_LATENCY_IRQ_WORD: res = {img[31:8], irq_line};
      // Unused windows, ROM base and reserved words stay all zero
      default: res = 32'h00000000; // R8 R13
    endcase
    return res;
  endfunction

  // ----------------
  // State
  // ----------------
  logic [15:0] cmd_reg, cmd_next;
  logic [15:0] lat_cls_reg, lat_cls_next;
  logic [31:WIN0_LSB] bar0_reg, bar0_next;
  logic [31:WIN1_LSB] bar1_reg, bar1_next;
  logic [31:WIN2_LSB] bar2_reg, bar2_next;
  logic [7:0] irq_line_reg, irq_line_next;
  logic [23:0] pass_base_reg, pass_base_next;
  logic pass_en_reg, pass_en_next;
  logic s1_valid_reg, s1_valid_next;
  logic s1_host_reg, s1_host_next;
  logic [5:0] s1_ofs_reg, s1_ofs_next;
  logic [31:0] cfg_rdata_reg, cfg_rdata_next;
  logic cfg_ack_reg, cfg_ack_next;
  logic [31:0] dsp_rdata_reg, dsp_rdata_next;
  logic dsp_ack_reg, dsp_ack_next;
  logic claim_reg, claim_next;
  logic [1:0] window_reg, window_next;
  logic [7:0] opreg_ofs_reg, opreg_ofs_next;
  logic [23:0] local_addr_reg, local_addr_next;
  logic ready_reg, ready_next;

  logic ld_wr_en;
  logic [4:0] ld_wr_idx;
  logic [31:0] ld_wr_data;
  logic ld_done;
  logic [3:0] mem_rd_addr;
  logic [31:0] mem_rd_data;
  logic idle;
  logic host_take_rd;
  logic host_take_wr;
  logic dsp_in_hdr;
  logic dsp_take;
  logic [31:0] cur_word;
  logic [31:0] new_word;
  logic hit0, hit1, hit2;

  // ----------------
  // Power-on image load and header store
  // ----------------
  pch_nvram_loader #(
    .HALF_CYC(NV_HALF_CYC),
    .WORDS(NV_WORDS)
  ) u_loader (
    .clock(clock),
    .rst(rst),
    .nv_miso(nv_miso),
    .nv_cs_n(nv_cs_n),
    .nv_sck(nv_sck),
    .nv_mosi(nv_mosi),
    .wr_en(ld_wr_en),
    .wr_idx(ld_wr_idx),
    .wr_data(ld_wr_data),
    .done(ld_done)
  );

  pch_header_mem #(
    .WIDTH(32),
    .DEPTH(16),
    .AW(4)
  ) u_mem (
    .clock(clock),
    .wr_en(ld_wr_en & ~ld_wr_idx[4]), // R10
    .wr_addr(ld_wr_idx[3:0]),
    .wr_data(ld_wr_data),
    .rd_addr(mem_rd_addr),
    .rd_data(mem_rd_data)
  );

  // ----------------
  // Request acceptance
  // ----------------
  // One access in flight; the cycle of an answer is skipped so a held
  // request is not taken twice.
  assign idle = ready_reg & ~s1_valid_reg & ~cfg_ack_reg & ~dsp_ack_reg;
  assign host_take_rd = idle & cfg_sel & cfg_rd; // R11
  assign host_take_wr = idle & cfg_sel & cfg_wr & ~cfg_rd; // R11
  assign dsp_in_hdr = (dsp_addr >= LOCAL_HDR_BASE) && (dsp_addr <= LOCAL_HDR_LAST);
  // Host configuration has priority; the local read waits a turn
  assign dsp_take = idle & dsp_rd & ~(cfg_sel & (cfg_rd | cfg_wr));
  assign mem_rd_addr = host_take_rd ? cfg_ofs[5:2] : dsp_addr[3:0]; // R1

  always_comb begin
    cur_word = hdr_view(cfg_ofs, 32'h00000000, cmd_reg, lat_cls_reg,
                        bar0_reg, bar1_reg, bar2_reg, irq_line_reg);
    new_word = be_merge(cur_word, cfg_wdata, cfg_be);
  end

  // ----------------
  // Header registers and read pipeline
  // ----------------
  always_comb begin
    cmd_next = cmd_reg;
    lat_cls_next = lat_cls_reg;
    bar0_next = bar0_reg;
    bar1_next = bar1_reg;
    bar2_next = bar2_reg;
    irq_line_next = irq_line_reg;
    pass_base_next = pass_base_reg;
    pass_en_next = pass_en_reg;
    ready_next = ready_reg | ld_done; // R10
    s1_valid_next = 1'b0;
    s1_host_next = s1_host_reg;
    s1_ofs_next = s1_ofs_reg;
    cfg_rdata_next = cfg_rdata_reg;
    cfg_ack_next = 1'b0;
    dsp_rdata_next = dsp_rdata_reg;
    dsp_ack_next = 1'b0;

    if (ld_wr_en) begin
      case (ld_wr_idx)
        5'(OFS_SELFTEST_HEADER_LATENCY_LINE[5:2]): lat_cls_next = ld_wr_data[15:0]; // R10
        5'(OFS_GRANT_LATENCY_IRQ_WORD[5:2]): irq_line_next = ld_wr_data[7:0]; // R10
        NV_PASS_IDX: begin
          pass_base_next = ld_wr_data[23:0]; // R7
          pass_en_next = ld_wr_data[NV_PASS_EN_BIT]; // R7
        end
        default: begin
        end
      endcase
    end

    if (host_take_wr) begin
      cfg_ack_next = 1'b1;
      // Only writable fields change; identity, class and reserved words drop the data
      case ({cfg_ofs[5:2], 2'b00})
        OFS_STATUS_COMMAND_WORD: cmd_next = new_word[15:0] & CMD_WR_MASK; // R13
        OFS_SELFTEST_HEADER_LATENCY_LINE: lat_cls_next = new_word[15:0];
        OFS_WINDOW0_BASE: bar0_next = new_word[31:WIN0_LSB]; // R3 R4
        OFS_WINDOW1_BASE: bar1_next = new_word[31:WIN1_LSB]; // R3 R5
        OFS_WINDOW2_BASE: bar2_next = new_word[31:WIN2_LSB]; // R3 R6
        OFS_GRANT_LATENCY_IRQ_WORD: irq_line_next = new_word[7:0];
        default: begin
        end
      endcase
    end else if (host_take_rd) begin
      s1_valid_next = 1'b1;
      s1_host_next = 1'b1;
      s1_ofs_next = cfg_ofs;
    end else if (dsp_take) begin
      s1_valid_next = 1'b1;
      s1_host_next = 1'b0;
      // Addresses outside the header answer zero through a reserved word
      s1_ofs_next = dsp_in_hdr ? {dsp_addr[3:0], 2'b00} : OFS_RESERVED_WORD_A; // R1
    end

    if (s1_valid_reg) begin
      if (s1_host_reg) begin
        cfg_rdata_next = hdr_view(s1_ofs_reg, mem_rd_data, cmd_reg, lat_cls_reg,
                                  bar0_reg, bar1_reg, bar2_reg, irq_line_reg);
        cfg_ack_next = 1'b1;
      end else begin
        dsp_rdata_next = hdr_view(s1_ofs_reg, mem_rd_data, cmd_reg, lat_cls_reg,
                                  bar0_reg, bar1_reg, bar2_reg, irq_line_reg); // R1
        dsp_ack_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cmd_reg <= CMD_RESET;
      lat_cls_reg <= 16'h0000;
      bar0_reg <= '0;
      bar1_reg <= '0;
      bar2_reg <= '0;
      irq_line_reg <= 8'h00;
      pass_base_reg <= 24'h000000;
      pass_en_reg <= 1'b0;
      ready_reg <= 1'b0;
      s1_valid_reg <= 1'b0;
      s1_host_reg <= 1'b0;
      s1_ofs_reg <= 6'h00;
      cfg_rdata_reg <= 32'h00000000;
      cfg_ack_reg <= 1'b0;
      dsp_rdata_reg <= 32'h00000000;
      dsp_ack_reg <= 1'b0;
    end else begin
      cmd_reg <= cmd_next;
      lat_cls_reg <= lat_cls_next;
      bar0_reg <= bar0_next;
      bar1_reg <= bar1_next;
      bar2_reg <= bar2_next;
      irq_line_reg <= irq_line_next;
      pass_base_reg <= pass_base_next;
      pass_en_reg <= pass_en_next;
      ready_reg <= ready_next;
      s1_valid_reg <= s1_valid_next;
      s1_host_reg <= s1_host_next;
      s1_ofs_reg <= s1_ofs_next;
      cfg_rdata_reg <= cfg_rdata_next;
      cfg_ack_reg <= cfg_ack_next;
      dsp_rdata_reg <= dsp_rdata_next;
      dsp_ack_reg <= dsp_ack_next;
    end
  end

  // ----------------
  // Host access window decode
  // ----------------
  // Placement above the first megabyte is left to host software; the
  // compare does not enforce it.
  assign hit0 = cmd_reg[CMD_MEM_BIT] & ~acc_io & (acc_addr[31:WIN0_LSB] == bar0_reg); // R2 R4
  assign hit1 = cmd_reg[CMD_IO_BIT] & acc_io & (acc_addr[31:WIN1_LSB] == bar1_reg); // R2 R5
  assign hit2 = cmd_reg[CMD_MEM_BIT] & ~acc_io & pass_en_reg
                & (acc_addr[31:WIN2_LSB] == bar2_reg); // R2 R6 R7

  always_comb begin
    claim_next = acc_valid & ready_reg & (hit0 | hit1 | hit2); // R2
    window_next = window_reg;
    opreg_ofs_next = opreg_ofs_reg;
    local_addr_next = local_addr_reg;
    if (acc_valid & ready_reg) begin
      if (hit0) begin
        window_next = WIN_SEL_MEM_REGS;
        opreg_ofs_next = acc_addr[7:0]; // R4
      end else if (hit1) begin
        window_next = WIN_SEL_IO_REGS;
        opreg_ofs_next = acc_addr[7:0]; // R5
      end else if (hit2) begin
        window_next = WIN_SEL_PASS;
        // Local bus is word addressed: byte offset in the window over four
        local_addr_next = pass_base_reg + {5'b00000, acc_addr[20:2]}; // R6 R7
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      claim_reg <= 1'b0;
      window_reg <= WIN_SEL_MEM_REGS;
      opreg_ofs_reg <= 8'h00;
      local_addr_reg <= 24'h000000;
    end else begin
      claim_reg <= claim_next;
      window_reg <= window_next;
      opreg_ofs_reg <= opreg_ofs_next;
      local_addr_reg <= local_addr_next;
    end
  end

  // ----------------
  // Outputs
  // ----------------
  assign cfg_rdata = cfg_rdata_reg;
  assign cfg_ack = cfg_ack_reg;
  assign dsp_rdata = dsp_rdata_reg;
  assign dsp_ack = dsp_ack_reg;
  assign acc_claim = claim_reg;
  assign acc_window = window_reg;
  assign acc_opreg_ofs = opreg_ofs_reg;
  assign acc_local_addr = local_addr_reg;
  assign header_ready = ready_reg;

endmodule

// File: pch_pkg.sv
// Package: header layout, default values, window sizes and timing of the header bank
package pch_pkg;

  // ----------------
  // Header word offsets (byte offsets into configuration space)
  // ----------------
  localparam logic [5:0] OFS_IDENTITY_WORD = 6'h00;
  localparam logic [5:0] OFS_STATUS_COMMAND_WORD = 6'h04;
  localparam logic [5:0] OFS_CLASS_REVISION_WORD = 6'h08;
  localparam logic [5:0] OFS_SELFTEST_HEADER_LATENCY_LINE = 6'h0C;
  localparam logic [5:0] OFS_WINDOW0_BASE = 6'h10;
  localparam logic [5:0] OFS_WINDOW1_BASE = 6'h14;
  localparam logic [5:0] OFS_WINDOW2_BASE = 6'h18;
  localparam logic [5:0] OFS_WINDOW3_BASE_UNUSED = 6'h1C;
  localparam logic [5:0] OFS_WINDOW4_BASE_UNUSED = 6'h20;
  localparam logic [5:0] OFS_WINDOW5_BASE_UNUSED = 6'h24;
  localparam logic [5:0] OFS_CARD_INFO_POINTER = 6'h28;
  localparam logic [5:0] OFS_SUBSYSTEM_IDENTITY_WORD = 6'h2C;
  localparam logic [5:0] OFS_ROM_WINDOW_BASE = 6'h30;
  localparam logic [5:0] OFS_RESERVED_WORD_A = 6'h34;
  localparam logic [5:0] OFS_RESERVED_WORD_B = 6'h38;
  localparam logic [5:0] OFS_GRANT_LATENCY_IRQ_WORD = 6'h3C;

  // ----------------
  // Local view of the header
  // ----------------
  localparam logic [23:0] LOCAL_HDR_BASE = 24'h880000;
  localparam logic [23:0] LOCAL_HDR_LAST = 24'h88000F;

  // ----------------
  // Fixed field values and write masks
  // ----------------
  localparam logic [23:0] CLASS_NONE = 24'hFF0000;
  localparam logic [15:0] CMD_WR_MASK = 16'h0147;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam int CMD_IO_BIT = 0;
  localparam int CMD_MEM_BIT = 1;

  // ----------------
  // Windows: size in bytes, fixed low bits
  // ----------------
  localparam int WIN0_SIZE = 32'h100;
  localparam int WIN1_SIZE = 32'h100;
  localparam int WIN2_SIZE = 32'h200000;
  localparam int WIN0_LSB = 8;
  localparam int WIN1_LSB = 8;
  localparam int WIN2_LSB = 21;
  localparam logic [7:0] WIN0_LOW = 8'h00;
  localparam logic [7:0] WIN1_LOW = 8'h01;
  localparam logic [20:0] WIN2_LOW = 21'h000000;
  localparam logic [1:0] WIN_SEL_MEM_REGS = 2'h0;
  localparam logic [1:0] WIN_SEL_IO_REGS = 2'h1;
  localparam logic [1:0] WIN_SEL_PASS = 2'h2;

  // ----------------
  // NVRAM image and serial timing
  // ----------------
  localparam int NV_WORDS = 17;
  localparam logic [4:0] NV_PASS_IDX = 5'h10;
  localparam int NV_PASS_EN_BIT = 31;
  localparam logic [15:0] NV_READ_CMD = 16'h0300;
  localparam int CLOCK_PERIOD_NS = 25;
  localparam int NV_SCK_HALF_NS = 100;
  localparam int NV_SCK_HALF_CYC = (NV_SCK_HALF_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

endpackage

// File: pch_header_mem.sv
// Header image store: loaded once, read with a registered output
`timescale 1ns/100ps
module pch_header_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// File: pch_nvram_loader.sv
// Serial NVRAM reader that streams the header image out at power-on
`timescale 1ns/100ps
module pch_nvram_loader
  import pch_pkg::*;
#(
  parameter int HALF_CYC = NV_SCK_HALF_CYC,
  parameter int WORDS = NV_WORDS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic nv_miso,
  output logic nv_cs_n,
  output logic nv_sck,
  output logic nv_mosi,
  output logic wr_en,
  output logic [4:0] wr_idx,
  output logic [31:0] wr_data,
  output logic done
);

  typedef enum logic [2:0] {
    L_CMD = 3'b001,
    L_DATA = 3'b010,
    L_DONE = 3'b100
  } pch_load_state_t;

  pch_load_state_t state_reg, state_next;
  logic [7:0] div_reg, div_next;
  logic sck_reg, sck_next;
  logic cs_n_reg, cs_n_next;
  logic mosi_reg, mosi_next;
  logic [4:0] bit_reg, bit_next;
  logic [4:0] word_reg, word_next;
  logic [31:0] shift_reg, shift_next;
  logic wr_en_reg, wr_en_next;
  logic [4:0] wr_idx_reg, wr_idx_next;
  logic done_reg, done_next;
  logic sync1_reg, sync2_reg, sync3_reg;
  logic miso_reg, miso_next;
  logic tick;

  // ----------------
  // Input filter: value changes only when the last two stages agree
  // ----------------
  always_comb begin
    miso_next = (sync2_reg == sync3_reg) ? sync3_reg : miso_reg;
  end

  // ----------------
  // Serial sequencer
  // ----------------
  assign tick = (div_reg == 8'(HALF_CYC - 1));

  always_comb begin
    state_next = state_reg;
    div_next = tick ? 8'h00 : div_reg + 8'h01;
    sck_next = sck_reg;
    cs_n_next = cs_n_reg;
    mosi_next = mosi_reg;
    bit_next = bit_reg;
    word_next = word_reg;
    shift_next = shift_reg;
    wr_en_next = 1'b0;
    wr_idx_next = wr_idx_reg;
    done_next = done_reg;
    case (state_reg)
      L_CMD: begin
        cs_n_next = 1'b0;
        if (tick) begin
          sck_next = ~sck_reg;
          if (sck_reg) begin
            bit_next = bit_reg + 5'h01;
            mosi_next = NV_READ_CMD[4'hF - bit_next[3:0]];
            if (bit_reg == 5'h0F) begin
              bit_next = 5'h00;
              mosi_next = 1'b0;
              state_next = L_DATA;
            end
          end
        end
      end
      L_DATA: begin
        // Sample late in the high phase so the filtered input has settled
        if (tick) begin
          sck_next = ~sck_reg;
          if (sck_reg) begin
            shift_next = {shift_reg[30:0], miso_reg};
            bit_next = bit_reg + 5'h01;
            if (bit_reg == 5'h1F) begin
              wr_en_next = 1'b1;
              wr_idx_next = word_reg;
              word_next = word_reg + 5'h01;
              if (word_reg == 5'(WORDS - 1)) begin
                state_next = L_DONE;
                cs_n_next = 1'b1;
              end
            end
          end
        end
      end
      L_DONE: begin
        div_next = 8'h00;
        sck_next = 1'b0;
        cs_n_next = 1'b1;
        done_next = 1'b1;
      end
      default: begin
        state_next = L_DONE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    sync1_reg <= nv_miso;
    sync2_reg <= sync1_reg;
    sync3_reg <= sync2_reg;
    if (rst) begin
      state_reg <= L_CMD;
      div_reg <= 8'h00;
      sck_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      mosi_reg <= NV_READ_CMD[15];
      bit_reg <= 5'h00;
      word_reg <= 5'h00;
      shift_reg <= 32'h00000000;
      wr_en_reg <= 1'b0;
      wr_idx_reg <= 5'h00;
      done_reg <= 1'b0;
      miso_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      div_reg <= div_next;
      sck_reg <= sck_next;
      cs_n_reg <= cs_n_next;
      mosi_reg <= mosi_next;
      bit_reg <= bit_next;
      word_reg <= word_next;
      shift_reg <= shift_next;
      wr_en_reg <= wr_en_next;
      wr_idx_reg <= wr_idx_next;
      done_reg <= done_next;
      miso_reg <= miso_next;
    end
  end

  assign nv_cs_n = cs_n_reg;
  assign nv_sck = sck_reg;
  assign nv_mosi = mosi_reg;
  assign wr_en = wr_en_reg;
  assign wr_idx = wr_idx_reg;
  assign wr_data = shift_reg;
  assign done = done_reg;

endmodule

// File: pch_nv_model.sv
// Serial NVRAM model streaming the stored header image after a read command
`timescale 1ns/100ps
module pch_nv_model
  import pch_pkg::*;
#(
  parameter logic [543:0] IMAGE = 544'h0
) (
  input wire logic nv_cs_n,
  input wire logic nv_sck,
  input wire logic nv_mosi,
  output logic nv_miso
);
  int edges = 0;
  logic [15:0] cmd = 16'h0;
  initial nv_miso = 1'b0;
  // Released or idle line shows the inverse, so a stale sample is caught
  always @(nv_cs_n) begin
    edges = 0;
    nv_miso = ~nv_miso;
  end
  always @(posedge nv_sck) if (!nv_cs_n && edges < 16) cmd = {cmd[14:0], nv_mosi};
  always @(negedge nv_sck) begin
    if (!nv_cs_n) begin
      edges++;
      if (edges >= 16 && edges < 560 && cmd == NV_READ_CMD) begin
        nv_miso = IMAGE[((edges - 16) / 32) * 32 + 31 - (edges - 16) % 32];
      end else begin
        nv_miso = ~nv_miso;
      end
    end
  end
endmodule

// File: pch_header_bank_checker.sv
// Port assertions for the configuration header bank
`timescale 1ns/100ps
module pch_header_bank_checker
  import pch_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic cfg_sel,
  input wire logic cfg_rd,
  input wire logic [5:0] cfg_ofs,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_ack,
  input wire logic [23:0] dsp_addr,
  input wire logic [31:0] dsp_rdata,
  input wire logic dsp_ack,
  input wire logic acc_valid,
  input wire logic acc_io,
  input wire logic [31:0] acc_addr,
  input wire logic acc_claim,
  input wire logic [1:0] acc_window,
  input wire logic [7:0] acc_opreg_ofs,
  input wire logic nv_cs_n,
  input wire logic nv_sck,
  input wire logic header_ready
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_ack_single: assert property (cfg_ack |=> !cfg_ack)
    else $error("config ack too long");
  chk_sel_needed: assert property (cfg_ack |-> $past(cfg_sel))
    else $error("config ack unselected");
  chk_wait_ready: assert property (!header_ready |-> !cfg_ack && !dsp_ack)
    else $error("answer before load");
  chk_claim_cause: assert property (acc_claim |-> $past(acc_valid) && $past(header_ready))
    else $error("claim without access");
  chk_io_window: assert property (acc_claim && acc_window == WIN_SEL_IO_REGS
    |-> $past(acc_io))
    else $error("io window on memory access");
  chk_mem_window: assert property (acc_claim && acc_window != WIN_SEL_IO_REGS
    |-> !$past(acc_io))
    else $error("memory window on io access");
  chk_reg_offset: assert property (acc_claim && acc_window != WIN_SEL_PASS
    |-> acc_opreg_ofs == $past(acc_addr[7:0]))
    else $error("register offset wrong");
  chk_class_none: assert property (cfg_ack && $past(cfg_rd) && $past(cfg_ofs[5:2]) == 4'h2
    |-> cfg_rdata[31:8] == CLASS_NONE)
    else $error("class code wrong");
  chk_unused_zero: assert property (cfg_ack && $past(cfg_rd)
    && $past(cfg_ofs[5:2]) inside {4'h7, 4'h8, 4'h9, 4'hC, 4'hD, 4'hE}
    |-> cfg_rdata == 32'h0)
    else $error("unused word not zero");
  chk_local_outside: assert property (dsp_ack
    && !($past(dsp_addr) inside {[LOCAL_HDR_BASE:LOCAL_HDR_LAST]})
    |-> dsp_rdata == 32'h0)
    else $error("outside local read not zero");
  chk_sck_idle: assert property (nv_cs_n |-> !nv_sck)
    else $error("nvram clock moves deselected");
endmodule
bind pch_header_bank pch_header_bank_checker pch_header_bank_checker_i (.clock(clock), .rst(rst),
  .cfg_sel(cfg_sel), .cfg_rd(cfg_rd), .cfg_ofs(cfg_ofs), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
  .dsp_addr(dsp_addr), .dsp_rdata(dsp_rdata), .dsp_ack(dsp_ack), .acc_valid(acc_valid),
  .acc_io(acc_io), .acc_addr(acc_addr), .acc_claim(acc_claim), .acc_window(acc_window),
  .acc_opreg_ofs(acc_opreg_ofs), .nv_cs_n(nv_cs_n), .nv_sck(nv_sck), .header_ready(header_ready));

// File: tb_pch_header_bank.sv
// Self-checking bench for the configuration header bank
`timescale 1ns/100ps
module tb_pch_header_bank;
  import pch_pkg::*;
  typedef struct {logic wr; logic [5:0] ofs; logic [3:0] be; logic [31:0] val;} pch_row_t;
  // ----------------
  // Image and signals
  // ----------------
  localparam logic [31:0] W0 = 32'h5AA51234; // arbitrary identity value
  localparam logic [31:0] W15 = 32'h000001FF;
  localparam logic [543:0] IMG = {32'h80012340, W15, 352'h0, 32'h00004008, 32'h00000077,
    32'h02A00000, W0};
  logic clock = 1'b0, rst = 1'b1, cfg_sel = 1'b0, cfg_rd = 1'b0, cfg_wr = 1'b0;
  logic [5:0] cfg_ofs = 6'h00;
  logic [3:0] cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0, acc_addr = 32'h0, cfg_rdata, dsp_rdata;
  logic dsp_rd = 1'b0, acc_valid = 1'b0, acc_io = 1'b0, cfg_ack, dsp_ack, acc_claim;
  logic [23:0] dsp_addr = 24'h0, acc_local_addr;
  logic [1:0] acc_window;
  logic [7:0] acc_opreg_ofs;
  logic nv_miso, nv_cs_n, nv_sck, nv_mosi, header_ready;
  int err_count = 0, samples_checked = 0;
  pch_row_t rows [22] = '{
    '{1'b0, 6'h00, 4'hF, W0}, '{1'b1, 6'h00, 4'hF, 32'hFFFFFFFF}, '{1'b0, 6'h00, 4'hF, W0},
    '{1'b1, 6'h08, 4'hF, 32'hFFFFFFFF}, '{1'b0, 6'h08, 4'hF, 32'hFF000077},
    '{1'b0, 6'h3C, 4'hF, W15}, '{1'b1, 6'h0C, 4'h1, 32'hFFFFFF55},
    '{1'b0, 6'h0C, 4'hF, 32'h00004055}, '{1'b1, 6'h10, 4'hF, 32'hFFFFFFFF},
    '{1'b0, 6'h10, 4'hF, 32'hFFFFFF00}, '{1'b1, 6'h14, 4'hF, 32'hFFFFFFFF},
    '{1'b0, 6'h14, 4'hF, 32'hFFFFFF01}, '{1'b1, 6'h18, 4'hF, 32'hFFFFFFFF},
    '{1'b0, 6'h18, 4'hF, 32'hFFE00000}, '{1'b1, 6'h1C, 4'hF, 32'hFFFFFFFF},
    '{1'b0, 6'h1C, 4'hF, 32'h0}, '{1'b1, 6'h30, 4'hF, 32'hFFFFFFFF}, '{1'b0, 6'h30, 4'hF, 32'h0},
    '{1'b1, 6'h04, 4'hF, 32'hFFFFFFFF}, '{1'b0, 6'h04, 4'hF, 32'h02A00147},
    '{1'b0, 6'h34, 4'hF, 32'h0}, '{1'b1, 6'h04, 4'hF, 32'h00000003}};
  always #12.5 clock = ~clock;
  pch_nv_model #(.IMAGE(IMG)) pch_nv_model_i (.nv_cs_n(nv_cs_n), .nv_sck(nv_sck),
    .nv_mosi(nv_mosi), .nv_miso(nv_miso));
  pch_header_bank #(.NV_HALF_CYC(4)) pch_header_bank_i (.clock(clock), .rst(rst),
    .cfg_sel(cfg_sel), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_ofs(cfg_ofs), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .dsp_rd(dsp_rd),
    .dsp_addr(dsp_addr), .dsp_rdata(dsp_rdata), .dsp_ack(dsp_ack), .acc_valid(acc_valid),
    .acc_io(acc_io), .acc_addr(acc_addr), .acc_claim(acc_claim), .acc_window(acc_window),
    .acc_opreg_ofs(acc_opreg_ofs), .acc_local_addr(acc_local_addr), .nv_miso(nv_miso),
    .nv_cs_n(nv_cs_n), .nv_sck(nv_sck), .nv_mosi(nv_mosi), .header_ready(header_ready));
  // ----------------
  // Tasks
  // ----------------
  task automatic tally_and_finish;
    if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // Request is dropped at the edge that shows the ack, so it is never taken twice
  task automatic cfg(input logic wr, input logic [5:0] ofs, input logic [3:0] be,
    input logic [31:0] wd, output logic [31:0] rd);
    int n = 0;
    @(posedge clock);
    {cfg_sel, cfg_rd, cfg_wr, cfg_ofs, cfg_be, cfg_wdata} <= {1'b1, ~wr, wr, ofs, be, wd};
    do begin @(posedge clock); n++; end while (cfg_ack !== 1'b1 && n < 40);
    check("cfg ack", {31'h0, cfg_ack}, 32'h1);
    rd = cfg_rdata;
    {cfg_sel, cfg_rd, cfg_wr} <= 3'h0;
  endtask
  task automatic dsp(input logic [23:0] a, input logic [31:0] exp);
    int n = 0;
    @(posedge clock);
    {dsp_rd, dsp_addr} <= {1'b1, a};
    do begin @(posedge clock); n++; end while (dsp_ack !== 1'b1 && n < 40);
    check("local word", dsp_rdata, exp);
    dsp_rd <= 1'b0;
  endtask
  task automatic probe(input logic io, input logic [31:0] a, input logic c,
    input logic [1:0] w, input logic [23:0] la);
    @(posedge clock);
    {acc_valid, acc_io, acc_addr} <= {1'b1, io, a};
    @(posedge clock);
    acc_valid <= 1'b0;
    @(posedge clock);
    check("claim", {31'h0, acc_claim}, {31'h0, c});
    if (c) check("window", {30'h0, acc_window}, {30'h0, w});
    if (c && w == WIN_SEL_PASS) check("local addr", {8'h0, acc_local_addr}, {8'h0, la});
    else if (c) check("reg offset", {24'h0, acc_opreg_ofs}, {24'h0, a[7:0]});
  endtask
  // ----------------
  // Sequence
  // ----------------
  initial begin
    repeat (30000) @(posedge clock);
    err_count++;
    tally_and_finish();
  end
  initial begin
    logic [31:0] rd;
    int n;
    repeat (10) @(posedge clock);
    check("ready in reset", {31'h0, header_ready}, 32'h0);
    rst <= 1'b0;
    while (header_ready !== 1'b1 && n < 20000) begin @(posedge clock); n++; end
    foreach (rows[i]) begin
      cfg(rows[i].wr, rows[i].ofs, rows[i].be, rows[i].val, rd);
      if (!rows[i].wr) check("cfg word", rd, rows[i].val);
    end
    cfg(1'b1, 6'h10, 4'hF, 32'h12345600, rd);
    cfg(1'b1, 6'h14, 4'hF, 32'h0000AB00, rd);
    cfg(1'b1, 6'h18, 4'hF, 32'h40000000, rd);
    dsp(24'h880002, 32'hFF000077);
    dsp(24'h880004, 32'h12345600);
    dsp(24'h88000F, W15);
    dsp(24'h880010, 32'h0);
    probe(1'b0, 32'h12345640, 1'b1, WIN_SEL_MEM_REGS, 24'h0);
    probe(1'b1, 32'h0000AB10, 1'b1, WIN_SEL_IO_REGS, 24'h0);
    probe(1'b1, 32'h12345640, 1'b0, 2'h0, 24'h0);
    probe(1'b0, 32'h12345740, 1'b0, 2'h0, 24'h0);
    probe(1'b0, 32'h401FFFFC, 1'b1, WIN_SEL_PASS, 24'h09233F);
    probe(1'b0, 32'h40200000, 1'b0, 2'h0, 24'h0);
    cfg(1'b1, 6'h04, 4'hF, 32'h0, rd);
    probe(1'b0, 32'h12345640, 1'b0, 2'h0, 24'h0);
    @(posedge clock);
    {cfg_rd, cfg_ofs} <= {1'b1, 6'h00};
    n = 0;
    repeat (8) begin @(posedge clock); n += (cfg_ack === 1'b1); end
    cfg_rd <= 1'b0;
    check("unselected acks", n, 32'h0);
    tally_and_finish();
  end
endmodule
